// File: spsc_consts.svh
`ifndef SPSC_CONSTS_SVH
`define SPSC_CONSTS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SPSC_DIV_W      8
`define SPSC_LEN_W      9
`define SPSC_WORD_W     8
`define SPSC_BIT_W      3
`define SPSC_LAST_BIT   3'h7

// ----------------------------------------------------------------
// Mode codes and required settings
// ----------------------------------------------------------------
`define SPSC_STOP_LOW   2'h2
`define SPSC_STOP_FULL  2'h3
`define SPSC_SLV_SRC    1'h1
`define SPSC_SLV_DIV    8'h01

// ----------------------------------------------------------------
// Timing: CPU clock period in ns, phase counts in CPU clock cycles
// ----------------------------------------------------------------
`define SPSC_CPU_NS     4
`define SPSC_MIN_PHASE  9'h001

`endif

// File: spsc_pkg.sv
`include "spsc_consts.svh"

package spsc_pkg;

  // --------------------------------------------------------------
  // Configuration bits
  // --------------------------------------------------------------
  typedef struct packed {
    logic [1:0]              clock_stop_select;
    logic                    tx_clock_polarity;
    logic [`SPSC_DIV_W-1:0]  clock_divider_value;
    logic                    clock_source_select;
    logic                    rx_sync_polarity;
    logic                    tx_sync_polarity;
    logic                    tx_clock_direction;
    logic                    tx_sync_direction;
    logic                    rx_clock_direction;
    logic                    rx_sync_direction;
    logic [1:0]              bus_clock_divide_field;
  } spsc_cfg_t;

  // --------------------------------------------------------------
  // Master sequencer
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    M_IDLE,
    M_LEAD,
    M_SHIFT,
    M_TAIL
  } spsc_mst_state_t;

endpackage : spsc_pkg

// File: spsc_clkgen.sv
`timescale 1ns/10ps
`include "spsc_consts.svh"

module spsc_clkgen
  import spsc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Control
  input  wire logic                    run,
  input  wire logic [`SPSC_DIV_W-1:0]  div,
  // Bit clock and edge marks
  output logic                         sclk,
  output logic                         rise,
  output logic                         fall,
  // Phase lengths
  output logic [`SPSC_LEN_W-1:0]       lo_len,
  output logic [`SPSC_LEN_W-1:0]       hi_len,
  output logic [`SPSC_LEN_W-1:0]       tot_len
);

  logic [`SPSC_LEN_W-1:0] cnt;
  logic [`SPSC_LEN_W-1:0] next_cnt;
  logic [`SPSC_LEN_W-1:0] lo_raw;
  logic                   next_sclk;
  logic                   next_rise;
  logic                   next_fall;

  // ----------------------------------------------------------------
  // Phase lengths
  // ----------------------------------------------------------------
  always_comb
  begin
    tot_len = {1'b0, div} + `SPSC_MIN_PHASE;
    lo_raw  = tot_len >> 1;
    hi_len  = tot_len - lo_raw;
    // A zero divider cannot make half-cycle phases
    lo_len  = (lo_raw == '0) ? `SPSC_MIN_PHASE : lo_raw;
  end

  // ----------------------------------------------------------------
  // Phase counter
  // ----------------------------------------------------------------
  always_comb
  begin
    next_cnt  = cnt + `SPSC_MIN_PHASE;
    next_sclk = sclk;
    next_rise = 1'b0;
    next_fall = 1'b0;
    if (!run)
    begin
      next_cnt  = '0;
      next_sclk = 1'b0;
    end
    else if (!sclk && next_cnt == lo_len)
    begin
      next_cnt  = '0;
      next_sclk = 1'b1;
      next_rise = 1'b1;
    end
    else if (sclk && next_cnt == hi_len)
    begin
      next_cnt  = '0;
      next_sclk = 1'b0;
      next_fall = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt  <= '0;
      sclk <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else
    begin
      cnt  <= next_cnt;
      sclk <= next_sclk;
      rise <= next_rise;
      fall <= next_fall;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [`SPSC_LEN_W-1:0] mon_len;
  logic [`SPSC_LEN_W-1:0] mon_hi;
  logic                   mon_prev;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mon_len  <= '0;
      mon_hi   <= '0;
      mon_prev <= 1'b0;
    end
    else
    begin
      mon_prev <= sclk;
      // Idle time before a word must not count as low phase
      if (!run)
        mon_len <= '0;
      else
        mon_len <= (sclk != mon_prev) ? `SPSC_MIN_PHASE
                                       : mon_len + `SPSC_MIN_PHASE;
      if (!sclk && mon_prev)
        mon_hi <= mon_len;
    end
  end

  a_low_width: assert property (@(posedge clk) disable iff (rst)
    rise |-> mon_len == lo_len)
    else $error("bit clock low phase has the wrong length");

  a_high_width: assert property (@(posedge clk) disable iff (rst)
    fall |-> mon_len == hi_len)
    else $error("bit clock high phase has the wrong length");

  a_clock_period: assert property (@(posedge clk) disable iff (rst)
    rise && mon_hi != '0 && $past(run, 2) && div[0]
      |-> mon_len + mon_hi == tot_len)
    else $error("bit clock period differs from divider plus one");

endmodule : spsc_clkgen

// File: spsc_shifter.sv
`timescale 1ns/10ps
`include "spsc_consts.svh"

module spsc_shifter
  import spsc_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Strobes
  input  wire logic                     load,
  input  wire logic                     shift,
  input  wire logic                     sample,
  // Data
  input  wire logic [`SPSC_WORD_W-1:0]  tx_word,
  input  wire logic                     din,
  output logic                          dout,
  output logic [`SPSC_WORD_W-1:0]       rx_word,
  output logic                          rx_done
);

  logic [`SPSC_WORD_W-1:0] tx_sh;
  logic [`SPSC_WORD_W-1:0] rx_sh;
  logic [`SPSC_BIT_W-1:0]  nbit;
  logic [`SPSC_WORD_W-1:0] next_tx_sh;
  logic [`SPSC_WORD_W-1:0] next_rx_sh;
  logic [`SPSC_WORD_W-1:0] next_rx_word;
  logic [`SPSC_BIT_W-1:0]  next_nbit;
  logic                    next_dout;
  logic                    next_rx_done;

  // ----------------------------------------------------------------
  // Most significant bit first both ways
  // ----------------------------------------------------------------
  always_comb
  begin
    next_tx_sh   = tx_sh;
    next_rx_sh   = rx_sh;
    next_rx_word = rx_word;
    next_nbit    = nbit;
    next_dout    = dout;
    next_rx_done = 1'b0;
    if (load)
    begin
      next_tx_sh = tx_word;
      next_dout  = tx_word[`SPSC_WORD_W-1];
      next_nbit  = '0;
    end
    else if (shift)
    begin
      next_tx_sh = {tx_sh[`SPSC_WORD_W-2:0], 1'b0};
      next_dout  = tx_sh[`SPSC_WORD_W-2];
    end
    if (sample)
    begin
      next_rx_sh = {rx_sh[`SPSC_WORD_W-2:0], din};
      next_nbit  = nbit + 3'h1;
      if (nbit == `SPSC_LAST_BIT)
      begin
        next_rx_word = next_rx_sh;
        next_rx_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_sh   <= '0;
      rx_sh   <= '0;
      rx_word <= '0;
      nbit    <= '0;
      dout    <= 1'b0;
      rx_done <= 1'b0;
    end
    else
    begin
      tx_sh   <= next_tx_sh;
      rx_sh   <= next_rx_sh;
      rx_word <= next_rx_word;
      nbit    <= next_nbit;
      dout    <= next_dout;
      rx_done <= next_rx_done;
    end
  end

endmodule : spsc_shifter

// File: spsc_top.sv
`timescale 1ns/10ps
`include "spsc_consts.svh"

module spsc_top
  import spsc_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Configuration
  input  wire spsc_cfg_t                cfg,
  // Transmit word
  input  wire logic                     tx_valid,
  input  wire logic [`SPSC_WORD_W-1:0]  tx_data,
  output logic                          tx_ready,
  // Receive word
  output logic                          rx_valid,
  output logic [`SPSC_WORD_W-1:0]       rx_data,
  // Status
  output logic                          cfg_error,
  output logic                          busy,
  // Bit clock pin
  input  wire logic                     serial_tx_clock_pin_i,
  output logic                          serial_tx_clock_pin_o,
  output logic                          serial_tx_clock_pin_oe_n,
  // Frame sync pins
  input  wire logic                     tx_frame_sync_pin_i,
  output logic                          tx_frame_sync_pin_o,
  output logic                          tx_frame_sync_pin_oe_n,
  input  wire logic                     rx_frame_sync_pin_i,
  // Data pins
  output logic                          serial_data_out_pin_o,
  output logic                          serial_data_out_pin_oe_n,
  input  wire logic                     serial_data_in_pin_i
);

  spsc_mst_state_t         state;
  spsc_mst_state_t         next_state;
  logic [`SPSC_LEN_W-1:0]  timer;
  logic [`SPSC_LEN_W-1:0]  next_timer;
  logic [`SPSC_BIT_W-1:0]  fcnt;
  logic [`SPSC_BIT_W-1:0]  next_fcnt;
  logic [`SPSC_WORD_W-1:0] hold;
  logic [`SPSC_WORD_W-1:0] next_hold;
  logic                    hold_full;
  logic                    next_hold_full;
  logic                    slv_sel;
  logic                    next_slv_sel;
  logic                    sck_q;
  logic                    next_cfg_error;
  logic                    next_busy;
  logic                    next_fs_o;
  logic                    next_ck_oe_n;
  logic                    next_dout_oe_n;
  logic                    mst;
  logic                    m10;
  logic                    rise_ev;
  logic                    fall_ev;
  logic                    last_fall;
  logic                    in_frame;
  logic                    sel_act;
  logic                    rx_act;
  logic                    run_gen;
  logic                    sh_load;
  logic                    sh_shift;
  logic                    sh_sample;
  logic                    sh_done;
  logic [`SPSC_WORD_W-1:0] sh_word;
  logic [`SPSC_WORD_W-1:0] load_word;
  logic                    gen_rise;
  logic                    gen_fall;
  logic [`SPSC_LEN_W-1:0]  lo_len;
  logic [`SPSC_LEN_W-1:0]  hi_len;
  logic [`SPSC_LEN_W-1:0]  tot_len;

  // ----------------------------------------------------------------
  // Bit clock and shift register
  // ----------------------------------------------------------------
  // Runs straight on the CPU clock; bus divide never enters
  spsc_clkgen u_clkgen (
    .clk     (clk),
    .rst     (rst),
    .run     (run_gen),
    .div     (cfg.clock_divider_value),
    .sclk    (serial_tx_clock_pin_o),
    .rise    (gen_rise),
    .fall    (gen_fall),
    .lo_len  (lo_len),
    .hi_len  (hi_len),
    .tot_len (tot_len)
  );

  assign load_word = hold_full ? hold : '0;

  spsc_shifter u_shifter (
    .clk     (clk),
    .rst     (rst),
    .load    (sh_load),
    .shift   (sh_shift),
    .sample  (sh_sample),
    .tx_word (load_word),
    .din     (serial_data_in_pin_i),
    .dout    (serial_data_out_pin_o),
    .rx_word (sh_word),
    .rx_done (sh_done)
  );

  // ----------------------------------------------------------------
  // Role, mode and edge events
  // ----------------------------------------------------------------
  always_comb
  begin
    mst     = cfg.tx_clock_direction;
    m10     = cfg.clock_stop_select == `SPSC_STOP_LOW;
    // Active-low selects are turned active-high here
    sel_act = tx_frame_sync_pin_i ^ cfg.tx_sync_polarity;
    rx_act  = rx_frame_sync_pin_i ^ cfg.rx_sync_polarity;
    if (mst)
    begin
      rise_ev  = gen_rise;
      fall_ev  = gen_fall;
      in_frame = state == M_SHIFT;
    end
    else
    begin
      rise_ev  = serial_tx_clock_pin_i && !sck_q;
      fall_ev  = !serial_tx_clock_pin_i && sck_q;
      in_frame = slv_sel;
    end
    last_fall = fall_ev && fcnt == `SPSC_LAST_BIT;
    // Mode must be clock stop, polarity zero
    next_cfg_error = !cfg.clock_stop_select[1] || cfg.tx_clock_polarity;
    if (mst)
      next_cfg_error = next_cfg_error || !cfg.tx_sync_direction
                       || cfg.rx_clock_direction
                       || cfg.rx_sync_direction;
    else
      next_cfg_error = next_cfg_error || cfg.tx_sync_direction
                       || cfg.rx_clock_direction
                       || cfg.rx_sync_direction
                       || cfg.clock_source_select != `SPSC_SLV_SRC
                       || cfg.clock_divider_value != `SPSC_SLV_DIV;
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state     = state;
    next_timer     = timer;
    next_fcnt      = fcnt;
    next_hold      = hold;
    next_hold_full = hold_full;
    next_slv_sel   = slv_sel;
    sh_load        = 1'b0;
    sh_shift       = 1'b0;
    sh_sample      = 1'b0;
    // Stop on the last fall so no stray rise follows
    run_gen        = in_frame && mst && !last_fall;
    if (tx_valid && tx_ready)
    begin
      next_hold      = tx_data;
      next_hold_full = 1'b1;
    end
    if (in_frame)
    begin
      if (fall_ev)
        next_fcnt = fcnt + 3'h1;
      if (m10)
      begin
        if (rise_ev && fcnt == '0)
          sh_load = mst;
        else if (rise_ev)
          sh_shift = 1'b1;
        sh_sample = fall_ev;
      end
      else
      begin
        sh_sample = rise_ev;
        sh_shift  = fall_ev && !last_fall;
      end
      if (!mst)
        sh_sample = sh_sample && rx_act;
    end
    if (mst || cfg_error)
      next_slv_sel = 1'b0;
    else if (sel_act && !slv_sel)
    begin
      // Underrun sends zeros rather than stalling the master
      next_slv_sel   = 1'b1;
      next_fcnt      = '0;
      sh_load        = 1'b1;
      next_hold_full = 1'b0;
    end
    else if (!sel_act)
      next_slv_sel = 1'b0;
    unique case (state)
      M_IDLE:
      begin
        if (mst && !cfg_error && hold_full)
        begin
          next_fcnt      = '0;
          next_timer     = hi_len;
          next_state     = m10 ? M_SHIFT : M_LEAD;
        end
      end
      M_LEAD:
      begin
        next_timer = timer - `SPSC_MIN_PHASE;
        if (timer == `SPSC_MIN_PHASE)
        begin
          sh_load    = 1'b1;
          next_state = M_SHIFT;
        end
      end
      M_SHIFT:
      begin
        if (last_fall)
        begin
          next_timer = (m10 ? tot_len : lo_len) - `SPSC_MIN_PHASE;
          next_state = (next_timer == '0) ? M_IDLE : M_TAIL;
        end
      end
      M_TAIL:
      begin
        next_timer = timer - `SPSC_MIN_PHASE;
        if (timer == `SPSC_MIN_PHASE)
          next_state = M_IDLE;
      end
    endcase
    // Hold stays full until the shifter has the word, or zeros go out
    if (mst && sh_load)
      next_hold_full = 1'b0;
    if (!mst && state != M_IDLE)
      next_state = M_IDLE;
    next_fs_o      = (next_state != M_IDLE) ^ cfg.tx_sync_polarity;
    next_ck_oe_n   = !mst || next_cfg_error;
    next_dout_oe_n = mst ? next_state == M_IDLE : !next_slv_sel;
    next_busy      = next_state != M_IDLE || next_slv_sel;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state                    <= M_IDLE;
      timer                    <= '0;
      fcnt                     <= '0;
      hold                     <= '0;
      hold_full                <= 1'b0;
      slv_sel                  <= 1'b0;
      sck_q                    <= 1'b0;
      tx_ready                 <= 1'b0;
      rx_valid                 <= 1'b0;
      rx_data                  <= '0;
      cfg_error                <= 1'b0;
      busy                     <= 1'b0;
      tx_frame_sync_pin_o      <= 1'b0;
      serial_tx_clock_pin_oe_n <= 1'b1;
      tx_frame_sync_pin_oe_n   <= 1'b1;
      serial_data_out_pin_oe_n <= 1'b1;
    end
    else
    begin
      state                    <= next_state;
      timer                    <= next_timer;
      fcnt                     <= next_fcnt;
      hold                     <= next_hold;
      hold_full                <= next_hold_full;
      slv_sel                  <= next_slv_sel;
      sck_q                    <= serial_tx_clock_pin_i;
      tx_ready                 <= !next_hold_full;
      rx_valid                 <= sh_done;
      rx_data                  <= sh_word;
      cfg_error                <= next_cfg_error;
      busy                     <= next_busy;
      tx_frame_sync_pin_o      <= next_fs_o;
      serial_tx_clock_pin_oe_n <= next_ck_oe_n;
      tx_frame_sync_pin_oe_n   <= next_ck_oe_n;
      serial_data_out_pin_oe_n <= next_dout_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [`SPSC_LEN_W-1:0] sel_age;
  logic [`SPSC_LEN_W-1:0] since_fall;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sel_age    <= '0;
      since_fall <= '0;
    end
    else
    begin
      sel_age    <= (state == M_IDLE) ? '0 : sel_age + 9'h001;
      since_fall <= gen_fall ? 9'h001 : since_fall + 9'h001;
    end
  end

  a_lead_low: assert property (@(posedge clk) disable iff (rst)
    mst && m10 && gen_rise && fcnt == '0 |-> sel_age == lo_len)
    else $error("mode 10b select lead is not one low phase");

  a_lead_full: assert property (@(posedge clk) disable iff (rst)
    mst && !m10 && gen_rise && fcnt == '0 |-> sel_age == tot_len)
    else $error("mode 11b select lead is not one period");

  a_tail_hold: assert property (@(posedge clk) disable iff (rst)
    mst && $past(mst) && $changed(state) && state == M_IDLE
      && $past(state) != M_LEAD
      |-> since_fall == (m10 ? tot_len : lo_len))
    else $error("select hold after the last fall is wrong");

  a_idle_clock: assert property (@(posedge clk) disable iff (rst)
    state == M_IDLE ##1 state == M_IDLE |-> !serial_tx_clock_pin_o)
    else $error("bit clock not idle low between words");

  a_launch_edge: assert property (@(posedge clk) disable iff (rst)
    mst && state == M_SHIFT && $past(state) == M_SHIFT
      && $changed(serial_data_out_pin_o)
      |-> $past(m10 ? gen_rise : gen_fall))
    else $error("master data changed away from its launch edge");

  a_slave_release: assert property (@(posedge clk) disable iff (rst)
    !mst && !cfg_error && !sel_act |=> serial_data_out_pin_oe_n)
    else $error("slave kept driving data after select went away");

  a_fs_invert: assert property (@(posedge clk) disable iff (rst)
    mst && cfg.tx_sync_polarity && $past(busy) && busy
      |-> !tx_frame_sync_pin_o)
    else $error("active-low slave enable not low during a word");

  a_slave_cfg: assert property (@(posedge clk) disable iff (rst)
    !mst && slv_sel |-> cfg.clock_divider_value == `SPSC_SLV_DIV
      || cfg_error || $past(cfg_error))
    else $error("slave running with a divider other than one");

endmodule : spsc_top

// File: spsc_peer.sv
`timescale 1ns/10ps

module spsc_peer (
  // Link side
  input  wire logic       clk,
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic       late,
  input  wire logic       mosi,
  input  wire logic [7:0] word,
  output logic            miso,
  output logic [7:0]      got
);
  logic       prev;
  logic       skip;
  logic [7:0] sh;

  // Released line shows the inverse, never a stale copy
  assign miso = sel_n ? ~sh[7] : sh[7];

  always_ff @(posedge clk)
  begin
    prev <= sclk;
    if (sel_n)
    begin
      sh   <= word;
      skip <= 1'b1;
    end
    else if (sclk != prev)
    begin
      if (sclk == late)
        got <= {got[6:0], mosi};
      else
      begin
        if (late || !skip)
          sh <= {sh[6:0], 1'b0};
        skip <= 1'b0;
      end
    end
  end
endmodule : spsc_peer

// File: tb.sv
`timescale 1ns/10ps
`include "spsc_consts.svh"

module tb
  import spsc_pkg::*;
;
  logic clk = 1'b0;
  logic rst, tx_valid, tx_ready, rx_valid, cfg_error, busy, miso;
  logic ck_o, ck_oe_n, fs_o, fs_oe_n, dq_o, dq_oe_n, ck_w, fs_w, din;
  logic tb_ck, tb_fs, tb_d, slv, late;
  logic [7:0] tx_data, rx_data, pw, got;
  spsc_cfg_t cfg;
  int err_total, comparisons;

  always #2 clk = ~clk;
  assign ck_w = ck_oe_n ? tb_ck : ck_o;
  assign fs_w = fs_oe_n ? tb_fs : fs_o;
  assign din  = slv ? tb_d : miso;

  spsc_top dut (.clk(clk), .rst(rst), .cfg(cfg), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .cfg_error(cfg_error), .busy(busy),
    .serial_tx_clock_pin_i(ck_w), .serial_tx_clock_pin_o(ck_o),
    .serial_tx_clock_pin_oe_n(ck_oe_n), .tx_frame_sync_pin_i(fs_w),
    .tx_frame_sync_pin_o(fs_o), .tx_frame_sync_pin_oe_n(fs_oe_n),
    .rx_frame_sync_pin_i(tb_fs), .serial_data_out_pin_o(dq_o),
    .serial_data_out_pin_oe_n(dq_oe_n), .serial_data_in_pin_i(din));

  spsc_peer peer (.clk(clk), .sclk(ck_w), .sel_n(fs_w), .late(late),
    .mosi(dq_o), .word(pw), .miso(miso), .got(got));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic setup(input logic [1:0] m, input logic mst,
                       input logic [7:0] dv);
    @(negedge clk);
    rst = 1'b1;
    cfg = '0;
    cfg.clock_stop_select      = m;
    cfg.clock_divider_value    = dv;
    cfg.clock_source_select    = 1'b1;
    cfg.rx_sync_polarity       = 1'b1;
    cfg.tx_sync_polarity       = 1'b1;
    cfg.tx_clock_direction     = mst;
    cfg.tx_sync_direction      = mst;
    cfg.bus_clock_divide_field = dv[1:0];
    late = m[0];
    slv  = !mst;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk("clock oe_n", ck_oe_n, !mst);
    chk("sync oe_n", fs_oe_n, !mst);
  endtask : setup

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic master(input logic [1:0] m, input logic [7:0] dv, w, pv);
    int c, d, t, lead, hi, act, rises, n, tail, fr;
    logic was, prv;
    logic [7:0] rxw;
    c = (dv == 0) ? 1 : (dv[0] ? (dv + 1) / 2 : dv / 2);
    d = (dv == 0) ? 1 : (dv[0] ? (dv + 1) / 2 : dv / 2 + 1);
    t = c + d;
    setup(m, 1'b1, dv);
    {lead, hi, act, rises, tail, was, prv} = '0;
    rxw = ~pv;
    pw = pv;
    tx_data = w;
    tx_valid = 1'b1;
    @(negedge clk);
    tx_valid = 1'b0;
    for (n = 0; n < 3000 && tail < 6; n++)
    begin
      @(negedge clk);
      act = act + !fs_o;
      lead = lead + (!fs_o && rises == 0 && !ck_o);
      rises = rises + (ck_o && !prv);
      hi = hi + ck_o;
      if (fs_o && ck_o) chk("idle clock", 1, 0);
      if (busy == fs_o) chk("busy", busy, !fs_o);
      if (rx_valid) rxw = rx_data;
      if ((was && fs_o) || tail > 0) tail++;
      was = was | !fs_o;
      prv = ck_o;
    end
    if (tail < 6) err_total++;
    if (tail < 6) results();
    chk("lead", lead, m[0] ? t : c);
    chk("high", hi, 8 * d);
    chk("rises", rises, 8);
    // 10b tail is divider plus one, even where div 0 clamps the phases
    fr = m[0] ? 9 * t : 8 * t + dv + 1;
    chk("frame", act, fr);
    chk("sent", got, w);
    chk("received", rxw, pv);
    chk("busy after", busy, 0);
    chk("data oe_n after", dq_oe_n, 1);
    chk("ready after", tx_ready, 1);
    $display("master mode %0h div %0h done", m, dv);
  endtask : master

  task automatic slave(input logic [1:0] m, input logic [7:0] w, mw);
    int i;
    logic [7:0] seen;
    setup(m, 1'b0, 8'h01);
    chk("slave cfg error", cfg_error, 0);
    tx_data = w;
    tx_valid = 1'b1;
    @(negedge clk);
    tx_valid = 1'b0;
    tb_fs = 1'b0;
    repeat (4) @(negedge clk);
    for (i = 7; i >= 0; i--)
    begin
      tb_d = mw[i];
      tb_ck = !m[0];
      repeat (4) @(negedge clk);
      seen[i] = dq_o;
      tb_ck = m[0];
      repeat (4) @(negedge clk);
    end
    tb_ck = 1'b0;
    repeat (4) @(negedge clk);
    chk("data held", dq_oe_n, 0);
    chk("slave busy", busy, 1);
    tb_fs = 1'b1;
    tb_d = ~tb_d;
    repeat (3) @(negedge clk);
    chk("data released", dq_oe_n, 1);
    chk("slave sent", seen, w);
    chk("slave received", rx_data, mw);
    $display("slave mode %0h done", m);
  endtask : slave

  initial
  begin
    {rst, tx_valid, tx_data, tb_ck, tb_fs, tb_d, slv, late} = '1;
    {cfg, pw, err_total, comparisons} = '0;
    tx_valid = 1'b0;
    // Slave bit clock idles low, as polarity zero wants
    tb_ck = 1'b0;
    master(2'h2, 8'h00, 8'hA5, 8'h3C);
    master(2'h2, 8'h01, 8'h96, 8'hE1);
    master(2'h2, 8'h04, 8'h01, 8'h80);
    master(2'h3, 8'h03, 8'h5A, 8'hC3);
    master(2'h3, 8'h06, 8'hFF, 8'h00);
    slave(2'h2, 8'hC3, 8'h5A);
    slave(2'h3, 8'h81, 8'h7E);
    setup(2'h2, 1'b0, 8'h02);
    chk("bad slave divider", cfg_error, 1);
    $display("slave divider check done");
    results();
  end
endmodule : tb
